//--- e1am_pkg.sv
// Constants shared by the E1 receive alarm and overhead monitor.
package e1am_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [6:0] IDX_CFG = 7'h31;
  localparam logic [6:0] IDX_IND = 7'h35;
  localparam logic [6:0] IDX_FRM = 7'h36;
  localparam logic [6:0] IDX_MNT = 7'h37;
  localparam logic [6:0] IDX_TS0 = 7'h38;
  localparam logic [6:0] IDX_CLO = 7'h39;
  localparam logic [6:0] IDX_CHI = 7'h3a;
  localparam int         CH_N    = 8;
  // Configuration fields and reset value.
  localparam int         CFG_REMOTE_ALARM_CRITERION  = 3;
  localparam int         CFG_ALARM_SIGNAL_CRITERION  = 1;
  localparam int         CFG_UNFR  = 0;
  localparam logic [7:0] CFG_MASK  = 8'h0b;
  localparam logic [7:0] CFG_RST   = 8'h00;
  // Maintenance status and indication fields.
  localparam int         MNT_RAI   = 7;
  localparam int         MNT_RMAI  = 6;
  localparam int         MNT_ALARM_SIGNAL_DETECT_STATE  = 5;
  localparam int         MNT_RED   = 3;
  localparam int         MNT_AIS   = 2;
  localparam int         FRM_OOF   = 6;
  localparam int         FRM_CFEBE = 1;
  localparam int         FRM_LINK  = 0;
  // Detection thresholds.
  localparam logic [2:0] RAI_RUN   = 3'h4;
  localparam logic [1:0] Y_RUN     = 2'h3;
  localparam logic [8:0] AIS_LAST  = 9'h1ff;
  localparam logic [1:0] AIS_ZMIN  = 2'h3;
  localparam logic [9:0] FEBE_MIN  = 10'h3de;
  localparam logic [2:0] FEBE_SECS = 3'h5;
  localparam logic [9:0] CRC_MAX   = 10'h3ff;
  // Timing.
  localparam int         CLK_HZ     = 40000000;
  localparam int         SEC_MS     = 1000;
  localparam int         PERSIST_MS = 100;
  localparam int         SEC_CYC    = CLK_HZ / 1000 * SEC_MS;
  localparam int         PER_CYC    = CLK_HZ / 1000 * PERSIST_MS;
  localparam int         SEC_W      = 26;
  localparam int         PER_W      = 23;
endpackage

//--- e1am_top.sv
// E1 receive alarm and overhead monitor: eight channels behind Wishbone.
// Function
// - Far-end error persist set when >=990 errors per second for 5 seconds.
// - Link ID detected when 2 of last 3 Sa7 bits are zero.
// - Remote alarm: one A=1 or 4 consecutive, chosen by criterion bit.
// - Remote alarm state refreshed every two frames.
// - Multiframe alarm set after Y=1 in 3 multiframes, zero when Y=0.
// - Multiframe alarm state refreshed every 16 frames.
// - Alarm signal detection inhibited in unframed mode.
// - Detect: alignment lost and <3 zeros in one or two 512-bit blocks.
// - Clear: 3 or more zeros in one or two 512-bit blocks.
// - Alarm signal detect state updated once per 512 bits.
// - Frame loss persist follows alignment loss after 100 ms.
// - Alarm signal persist follows detect state after 100 ms.
// - TS0 register: Si1, Si0, A, Sa4..Sa8 from top down.
// - Si1 updates on alignment frames, rest on non-alignment frames.
// - TS0 register frozen while alignment is lost.
// - Ten-bit CRC error count split over two registers, moved each second.
// - Overwritten flag set when an unread count is replaced; read clears.
// - Updated flag set on each refresh and cleared on read.
// - X0, Y, X1, X2 captured from TS16 of multiframe frame 0.
// - TS16 bits refreshed on non-alignment frames, frozen on loss.
// - Change indications latch every alarm transition; read clears.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module e1am_chan #(
  parameter int PERSIST_CYCLES = e1am_pkg::PER_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sec_tick,
  input  wire logic       frame_start_event,
  input  wire logic       fas_frame,
  input  wire logic       smf_frame0,
  input  wire logic [7:0] ts0_octet,
  input  wire logic [7:0] ts16_octet,
  input  wire logic       oof,
  input  wire logic       rx_bit_en,
  input  wire logic       rx_bit,
  input  wire logic       crc_err,
  input  wire logic       febe,
  input  wire logic [6:0] reg_idx,
  input  wire logic       rd_stb,
  input  wire logic       wr_stb,
  input  wire logic [7:0] wdat,
  output logic      [7:0] rdat
);
  import e1am_pkg::*;

  function automatic logic [9:0] sat_inc(logic [9:0] v, logic [9:0] m);
    return (v >= m) ? m : v + 10'h001;
  endfunction

  // A level must disagree with its state for the full window to flip it.
  function automatic logic [PER_W:0] persist(logic cond, logic st,
                                             logic [PER_W-1:0] c);
    if (cond == st) begin
      return {st, {PER_W{1'b0}}};
    end else if (c >= PER_W'(PERSIST_CYCLES - 1)) begin
      return {cond, {PER_W{1'b0}}};
    end
    return {st, c + {{(PER_W-1){1'b0}}, 1'b1}};
  endfunction

  logic [7:0] cfg_q, cfg_d;
  logic [2:0] rai_run_q, rai_run_d;
  logic       rai_last_q, rai_last_d, rai_q, rai_d, fpar_q, fpar_d;
  logic [1:0] y_run_q, y_run_d;
  logic       rmai_q, rmai_d;
  logic [3:0] f16_q, f16_d;
  logic [8:0] blk_q, blk_d;
  logic [1:0] zer_q, zer_d;
  logic       plow_q, plow_d, alarm_signal_detect_state_q, alarm_signal_detect_state_d;
  logic       red_q, red_d, ais_q, ais_d;
  logic [PER_W-1:0] redc_q, redc_d, alarm_signal_criterion_q, alarm_signal_criterion_d;
  logic [9:0] febc_q, febc_d;
  logic [2:0] good_q, good_d;
  logic       cfebe_q, cfebe_d;
  logic [2:0] sa7_q, sa7_d;
  logic       link_q, link_d;
  logic [7:0] ts0_q, ts0_d;
  logic [3:0] xy_q, xy_d;
  logic [9:0] acc_q, acc_d, crc_q, crc_d;
  logic       ovr_q, ovr_d, new_q, new_d, unrd_q, unrd_d;
  logic [7:0] ind_q, ind_d;

  logic       nfas_ev, fas_ev, blk_low, blk_end;
  logic [1:0] z_now;
  logic [9:0] febe_now, acc_now;
  logic [PER_W:0] red_p, ais_p;

  always_comb begin
    cfg_d     = cfg_q;
    rai_run_d = rai_run_q;
    rai_last_d = rai_last_q;
    rai_d     = rai_q;
    fpar_d    = fpar_q;
    y_run_d   = y_run_q;
    rmai_d    = rmai_q;
    f16_d     = f16_q;
    alarm_signal_detect_state_d    = alarm_signal_detect_state_q;
    plow_d    = plow_q;
    sa7_d     = sa7_q;
    ts0_d     = ts0_q;
    xy_d      = xy_q;
    crc_d     = crc_q;
    good_d    = good_q;
    cfebe_d   = cfebe_q;
    ovr_d     = ovr_q;
    new_d     = new_q;
    unrd_d    = unrd_q;
    ind_d     = ind_q;
    nfas_ev   = frame_start_event & ~fas_frame & ~oof;
    fas_ev    = frame_start_event & fas_frame & ~oof;

    if (wr_stb && reg_idx == IDX_CFG) begin
      cfg_d = wdat & CFG_MASK;
    end

    // Frame-rate overhead capture, frozen while alignment is lost.
    if (fas_ev) begin
      ts0_d[7] = ts0_octet[7];
    end
    if (nfas_ev) begin
      // The non-alignment international bit is the first bit on the line.
      ts0_d[6]   = ts0_octet[7];
      ts0_d[5:0] = ts0_octet[5:0];
      rai_last_d = ts0_octet[5];
      rai_run_d  = ts0_octet[5] ? 3'(sat_inc(10'(rai_run_q), 10'(RAI_RUN)))
                                : 3'h0;
      sa7_d      = {sa7_q[1:0], ts0_octet[1]};
      if (smf_frame0) begin
        xy_d    = ts16_octet[3:0];
        y_run_d = ts16_octet[2] ? 2'(sat_inc(10'(y_run_q), 10'(Y_RUN)))
                                : 2'h0;
      end
    end
    link_d = (~sa7_d[0] & ~sa7_d[1]) | (~sa7_d[0] & ~sa7_d[2]) |
             (~sa7_d[1] & ~sa7_d[2]);

    if (frame_start_event) begin
      fpar_d = ~fpar_q;
      f16_d  = f16_q + 4'h1;
      if (fpar_q) begin
        rai_d = cfg_q[CFG_REMOTE_ALARM_CRITERION] ? (rai_run_d >= RAI_RUN)
                                : rai_last_d;
      end
      if (f16_q == 4'hf) begin
        rmai_d = (y_run_d >= Y_RUN);
      end
    end

    // Zero density over 512-bit blocks.
    z_now   = (rx_bit_en && !rx_bit) ? 2'(sat_inc(10'(zer_q), 10'(AIS_ZMIN)))
                                     : zer_q;
    blk_end = rx_bit_en && (blk_q == AIS_LAST);
    blk_low = (z_now < AIS_ZMIN);
    blk_d   = rx_bit_en ? blk_q + 9'h001 : blk_q;
    zer_d   = blk_end ? 2'h0 : z_now;
    if (blk_end) begin
      plow_d = blk_low;
      if (cfg_q[CFG_UNFR]) begin
        alarm_signal_detect_state_d = 1'b0;
      end else if (oof && blk_low &&
                   (!cfg_q[CFG_ALARM_SIGNAL_CRITERION] || plow_q)) begin
        alarm_signal_detect_state_d = 1'b1;
      end else if (!blk_low && (!cfg_q[CFG_ALARM_SIGNAL_CRITERION] || !plow_q)) begin
        alarm_signal_detect_state_d = 1'b0;
      end
    end

    red_p  = persist(oof, red_q, redc_q);
    red_d  = red_p[PER_W];
    redc_d = red_p[PER_W-1:0];
    ais_p  = persist(alarm_signal_detect_state_q, ais_q, alarm_signal_criterion_q);
    ais_d  = ais_p[PER_W];
    alarm_signal_criterion_d = ais_p[PER_W-1:0];

    // One-second counting; an event in the tick cycle joins the old second.
    febe_now = febe ? sat_inc(febc_q, FEBE_MIN) : febc_q;
    acc_now  = crc_err ? sat_inc(acc_q, CRC_MAX) : acc_q;
    febc_d   = sec_tick ? 10'h000 : febe_now;
    acc_d    = sec_tick ? 10'h000 : acc_now;

    // Reads clear first so that a coincident set wins.
    if (rd_stb && (reg_idx == IDX_CLO || reg_idx == IDX_CHI)) begin
      unrd_d = 1'b0;
    end
    if (rd_stb && reg_idx == IDX_CHI) begin
      ovr_d = 1'b0;
      new_d = 1'b0;
    end
    if (rd_stb && reg_idx == IDX_IND) begin
      ind_d = 8'h00;
    end
    if (sec_tick) begin
      good_d  = (febe_now >= FEBE_MIN) ?
                3'(sat_inc(10'(good_q), 10'(FEBE_SECS))) : 3'h0;
      cfebe_d = (good_d == FEBE_SECS);
      crc_d   = acc_now;
      new_d   = 1'b1;
      unrd_d  = 1'b1;
      if (unrd_q) begin
        ovr_d = 1'b1;
      end
    end

    ind_d[MNT_RAI]  = ind_d[MNT_RAI]  | (rai_d ^ rai_q);
    ind_d[MNT_RMAI] = ind_d[MNT_RMAI] | (rmai_d ^ rmai_q);
    ind_d[MNT_ALARM_SIGNAL_DETECT_STATE] = ind_d[MNT_ALARM_SIGNAL_DETECT_STATE] | (alarm_signal_detect_state_d ^ alarm_signal_detect_state_q);
    ind_d[MNT_RED]  = ind_d[MNT_RED]  | (red_d ^ red_q);
    ind_d[MNT_AIS]  = ind_d[MNT_AIS]  | (ais_d ^ ais_q);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_q    <= CFG_RST;
      rai_run_q <= 3'h0;
      rai_last_q <= 1'b0;
      rai_q    <= 1'b0;
      fpar_q   <= 1'b0;
      y_run_q  <= 2'h0;
      rmai_q   <= 1'b0;
      f16_q    <= 4'h0;
      blk_q    <= 9'h000;
      zer_q    <= 2'h0;
      plow_q   <= 1'b0;
      alarm_signal_detect_state_q   <= 1'b0;
      red_q    <= 1'b0;
      redc_q   <= '0;
      ais_q    <= 1'b0;
      alarm_signal_criterion_q   <= '0;
      febc_q   <= 10'h000;
      good_q   <= 3'h0;
      cfebe_q  <= 1'b0;
      sa7_q    <= 3'h7;
      link_q   <= 1'b0;
      ts0_q    <= 8'h00;
      xy_q     <= 4'h0;
      acc_q    <= 10'h000;
      crc_q    <= 10'h000;
      ovr_q    <= 1'b0;
      new_q    <= 1'b0;
      unrd_q   <= 1'b0;
      ind_q    <= 8'h00;
    end else begin
      cfg_q    <= cfg_d;
      rai_run_q <= rai_run_d;
      rai_last_q <= rai_last_d;
      rai_q    <= rai_d;
      fpar_q   <= fpar_d;
      y_run_q  <= y_run_d;
      rmai_q   <= rmai_d;
      f16_q    <= f16_d;
      blk_q    <= blk_d;
      zer_q    <= zer_d;
      plow_q   <= plow_d;
      alarm_signal_detect_state_q   <= alarm_signal_detect_state_d;
      red_q    <= red_d;
      redc_q   <= redc_d;
      ais_q    <= ais_d;
      alarm_signal_criterion_q   <= alarm_signal_criterion_d;
      febc_q   <= febc_d;
      good_q   <= good_d;
      cfebe_q  <= cfebe_d;
      sa7_q    <= sa7_d;
      link_q   <= link_d;
      ts0_q    <= ts0_d;
      xy_q     <= xy_d;
      acc_q    <= acc_d;
      crc_q    <= crc_d;
      ovr_q    <= ovr_d;
      new_q    <= new_d;
      unrd_q   <= unrd_d;
      ind_q    <= ind_d;
    end
  end

  always_comb begin
    rdat = 8'h00;
    case (reg_idx)
      IDX_CFG: rdat = cfg_q;
      IDX_IND: rdat = ind_q;
      IDX_FRM: rdat = {1'b0, oof, 4'h0, cfebe_q, link_q};
      IDX_MNT: rdat = {rai_q, rmai_q, alarm_signal_detect_state_q, 1'b0, red_q, ais_q, 2'h0};
      IDX_TS0: rdat = ts0_q;
      IDX_CLO: rdat = crc_q[7:0];
      IDX_CHI: rdat = {ovr_q, new_q, xy_q, crc_q[9:8]};
      default: rdat = 8'h00;
    endcase
  end
endmodule // e1am_chan

module e1am_top #(
  parameter int SEC_CYCLES     = e1am_pkg::SEC_CYC,
  parameter int PERSIST_CYCLES = e1am_pkg::PER_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  frame_start_event,
  input  wire logic [7:0]  fas_frame,
  input  wire logic [7:0]  smf_frame0,
  input  wire logic [63:0] ts0_octet,
  input  wire logic [63:0] ts16_octet,
  input  wire logic [7:0]  oof,
  input  wire logic [7:0]  rx_bit_en,
  input  wire logic [7:0]  rx_bit,
  input  wire logic [7:0]  crc_err,
  input  wire logic [7:0]  febe
);
  import e1am_pkg::*;

  logic [SEC_W-1:0] sec_q, sec_d;
  logic             sec_tick;
  logic             ack_q, ack_d;
  logic [7:0]       dat_q, dat_d;
  logic             acc;
  logic [2:0]       ch_sel;
  logic [6:0]       reg_idx;
  logic [7:0]       ch_rdat [CH_N];

  // One divider serves all channels so their seconds stay aligned.
  assign sec_tick = (sec_q == SEC_W'(SEC_CYCLES - 1));
  assign ch_sel   = wb_adr_i[11:9];
  assign reg_idx  = wb_adr_i[8:2];
  assign acc      = wb_cyc_i & wb_stb_i & ~ack_q;

  always_comb begin
    sec_d = sec_tick ? '0 : sec_q + {{(SEC_W-1){1'b0}}, 1'b1};
    ack_d = acc;
    dat_d = acc ? (wb_we_i ? 8'h00 : ch_rdat[ch_sel]) : dat_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sec_q <= '0;
      ack_q <= 1'b0;
      dat_q <= 8'h00;
    end else begin
      sec_q <= sec_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = {24'h000000, dat_q};

  for (genvar i = 0; i < CH_N; i++) begin : g_ch
    e1am_chan #(
      .PERSIST_CYCLES(PERSIST_CYCLES)
    ) u_chan (
      .clk              (clk),
      .rst_n            (rst_n),
      .sec_tick         (sec_tick),
      .frame_start_event(frame_start_event[i]),
      .fas_frame        (fas_frame[i]),
      .smf_frame0       (smf_frame0[i]),
      .ts0_octet        (ts0_octet[8*i +: 8]),
      .ts16_octet       (ts16_octet[8*i +: 8]),
      .oof              (oof[i]),
      .rx_bit_en        (rx_bit_en[i]),
      .rx_bit           (rx_bit[i]),
      .crc_err          (crc_err[i]),
      .febe             (febe[i]),
      .reg_idx          (reg_idx),
      .rd_stb           (acc & ~wb_we_i & (ch_sel == 3'(i))),
      .wr_stb           (acc & wb_we_i & wb_sel_i[0] & (ch_sel == 3'(i))),
      .wdat             (wb_dat_i[7:0]),
      .rdat             (ch_rdat[i])
    );
  end
endmodule // e1am_top

`default_nettype wire

//--- e1am_asserts.sv
// Bus protocol and register shape checks for the alarm monitor top.
`timescale 1ns/1ps
`default_nettype none
module e1am_asserts
  import e1am_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [11:0] wb_adr_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd(logic [6:0] idx);
    s_req ##0 (!wb_we_i && wb_adr_i[8:2] == idx);
  endsequence
  a_ack_after_req: assert property (s_req |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o)
    |=> !wb_ack_o) else $error("ack without a request");
  a_upper_lanes_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  a_status_spare_zero: assert property (s_rd(IDX_MNT) |=>
    wb_dat_o[4] == 1'b0 && wb_dat_o[1:0] == 2'h0)
    else $error("spare status bits not zero");
  a_cfg_field_mask: assert property (s_rd(IDX_CFG) |=>
    (wb_dat_o[7:0] & ~CFG_MASK) == 8'h00) else $error("config spare bits set");
  a_unmapped_zero: assert property (s_rd(7'h00) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_n |=> !wb_ack_o && wb_dat_o == 32'h0) else $error("bus active in reset");
endmodule // e1am_asserts
bind e1am_top e1am_asserts u_chk (.clk(clk), .rst_n(rst_n),
  .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire

//--- e1am_line_model.sv
// Far-end E1 terminal model: frame marks, overhead octets and bit stream.
`timescale 1ns/1ps
`default_nettype none
module e1am_line_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       a_bit,
  input  wire logic [4:0] sa,
  input  wire logic       y_bit,
  input  wire logic       ones,
  input  wire logic       febe_on,
  output logic            fse,
  output logic            fas,
  output logic            smf0,
  output logic      [7:0] ts0,
  output logic      [7:0] ts16,
  output logic            bit_v,
  output logic            febe
);
  logic [2:0] ph_q;
  logic [3:0] fn_q;
  logic       tog_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_q  <= 3'h0;
      fn_q  <= 4'h0;
      tog_q <= 1'b0;
    end else begin
      ph_q  <= ph_q + 3'h1;
      tog_q <= ~tog_q;
      if (ph_q == 3'h7) fn_q <= fn_q + 4'h1;
    end
  end
  // A frame lasts eight clocks so that multiframes stay short.
  assign fse   = rst_n && ph_q == 3'h0;
  assign fas   = !fn_q[0];
  assign smf0  = fn_q == 4'h1;
  assign ts0   = fas ? 8'h9b : {2'b01, a_bit, sa};
  // Outside frame 0 the slot moves every cycle so a stray capture shows.
  assign ts16  = smf0 ? {5'h01, y_bit, 2'b01} : {4{tog_q, !tog_q}};
  assign bit_v = ones | tog_q;
  assign febe  = febe_on & tog_q;
endmodule // e1am_line_model
`default_nettype wire

//--- test_e1am_top.sv
// Self-checking bench for the E1 alarm and overhead monitor.
`timescale 1ns/1ps
`default_nettype none
module test_e1am_top;
  import e1am_pkg::*;
  localparam int SEC = 2000;
  localparam int PER = 200;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] adr = 12'h0;
  logic [31:0] wdat = 32'h0;
  logic        we = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic [31:0] rdat;
  logic        ack;
  logic        a_bit = 1'b0;
  logic [4:0]  sa = 5'h16;
  logic        y_bit = 1'b0;
  logic        lost = 1'b0;
  logic        ones = 1'b0;
  logic        febe_on = 1'b0;
  logic        crc = 1'b0;
  logic        fse, fas, smf0, bit_v, febe;
  logic [7:0]  ts0, ts16;
  int          bad_count = 0;
  int          checks = 0;
  always #12.5 clk = ~clk;
  e1am_line_model u_line (.clk(clk), .rst_n(rst_n), .a_bit(a_bit), .sa(sa),
    .y_bit(y_bit), .ones(ones), .febe_on(febe_on), .fse(fse), .fas(fas),
    .smf0(smf0), .ts0(ts0), .ts16(ts16), .bit_v(bit_v), .febe(febe));
  e1am_top #(.SEC_CYCLES(SEC), .PERSIST_CYCLES(PER)) u_dut (.clk(clk),
    .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'h1),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
    .wb_ack_o(ack), .frame_start_event({8{fse}}), .fas_frame({8{fas}}),
    .smf_frame0({8{smf0}}), .ts0_octet({8{ts0}}), .ts16_octet({8{ts16}}),
    .oof({8{lost}}), .rx_bit_en({8{rst_n}}), .rx_bit({8{bit_v}}),
    .crc_err({8{crc}}), .febe({8{febe}}));
  task automatic close_out;
    $display("mismatches %0d of %0d checks", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [2:0] ch, input logic [6:0] i,
                    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {ch, i, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdm(input logic [6:0] i, input logic [7:0] m,
                     input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, 3'h0, i, 8'h00, q);
    chk(q & m, e);
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, 3'h0, i, d, q);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic t_capture;
    logic [7:0] q;
    rdm(IDX_CFG, 8'hff, CFG_RST);
    rdm(IDX_MNT, 8'hff, 8'h00);
    rdm(IDX_CHI, 8'hc0, 8'h00);
    rdm(7'h00, 8'hff, 8'h00);
    idle(40);
    wr(IDX_TS0, 8'h00);
    rdm(IDX_TS0, 8'hff, 8'h96);
    wb(1'b0, 3'h7, IDX_TS0, 8'h00, q);
    chk(q, 8'h96);
    rdm(IDX_CHI, 8'h3c, 8'h24);
    rdm(IDX_FRM, 8'h01, 8'h00);
    sa <= 5'h14;
    idle(60);
    rdm(IDX_FRM, 8'h01, 8'h01);
    lost  <= 1'b1;
    sa    <= 5'h0b;
    y_bit <= 1'b1;
    idle(160);
    rdm(IDX_TS0, 8'hff, 8'h94);
    rdm(IDX_CHI, 8'h10, 8'h00);
    lost  <= 1'b0;
    sa    <= 5'h16;
    y_bit <= 1'b0;
  endtask
  task automatic t_remote;
    wr(IDX_CFG, 8'h08);
    idle(600);
    rdm(IDX_IND, 8'hff, 8'h00);
    a_bit <= 1'b1;
    idle(40);
    rdm(IDX_MNT, 8'h80, 8'h00);
    idle(60);
    rdm(IDX_MNT, 8'h80, 8'h80);
    rdm(IDX_IND, 8'h80, 8'h80);
    rdm(IDX_IND, 8'h80, 8'h00);
    wr(IDX_CFG, 8'h00);
    a_bit <= 1'b0;
    idle(40);
    rdm(IDX_MNT, 8'h80, 8'h00);
    a_bit <= 1'b1;
    idle(40);
    rdm(IDX_MNT, 8'h80, 8'h80);
    a_bit <= 1'b0;
    y_bit <= 1'b1;
    idle(640);
    rdm(IDX_MNT, 8'h40, 8'h40);
    y_bit <= 1'b0;
    idle(300);
    rdm(IDX_MNT, 8'h40, 8'h00);
  endtask
  task automatic t_alarm_signal;
    wr(IDX_CFG, 8'h02);
    lost <= 1'b1;
    ones <= 1'b1;
    idle(600);
    rdm(IDX_MNT, 8'h20, 8'h00);
    idle(1100);
    rdm(IDX_MNT, 8'h28, 8'h28);
    idle(300);
    rdm(IDX_MNT, 8'h04, 8'h04);
    ones <= 1'b0;
    idle(1100);
    rdm(IDX_MNT, 8'h20, 8'h00);
    wr(IDX_CFG, 8'h03);
    ones <= 1'b1;
    idle(1600);
    rdm(IDX_MNT, 8'h20, 8'h00);
    wr(IDX_CFG, 8'h00);
    idle(600);
    rdm(IDX_MNT, 8'h20, 8'h20);
    wr(IDX_CFG, 8'h02);
    lost <= 1'b0;
    ones <= 1'b0;
    idle(1300);
    rdm(IDX_MNT, 8'h2c, 8'h00);
  endtask
  task automatic t_counts;
    logic [7:0] q;
    // Drop a stale updated flag so that the poll finds a fresh boundary.
    wb(1'b0, 3'h0, IDX_CHI, 8'h00, q);
    do begin
      wb(1'b0, 3'h0, IDX_CHI, 8'h00, q);
    end while (q[6] !== 1'b1);
    repeat (5) begin
      @(posedge clk);
      crc <= 1'b1;
      @(posedge clk);
      crc <= 1'b0;
    end
    do begin
      wb(1'b0, 3'h0, IDX_CHI, 8'h00, q);
    end while (q[6] !== 1'b1);
    chk(q & 8'hc3, 8'h40);
    rdm(IDX_CLO, 8'hff, 8'h05);
    idle(4100);
    rdm(IDX_CHI, 8'hc3, 8'hc0);
    rdm(IDX_CHI, 8'hc0, 8'h00);
    rdm(IDX_CLO, 8'hff, 8'h00);
    febe_on <= 1'b1;
    idle(6000);
    rdm(IDX_FRM, 8'h02, 8'h00);
    idle(6500);
    rdm(IDX_FRM, 8'h02, 8'h02);
    febe_on <= 1'b0;
    idle(2100);
    rdm(IDX_FRM, 8'h02, 8'h00);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_capture();
    t_remote();
    t_alarm_signal();
    t_counts();
    close_out();
  end
  // The run needs about 31000 cycles; the margin covers slow polling.
  initial begin
    #(25 * 60000);
    bad_count++;
    close_out();
  end
endmodule // test_e1am_top
`default_nettype wire
